/* rtl/hap_pkg.sv */
/*
  Constants shared by the host register access port and its register store.
  Assumes nothing of its surroundings; every user names items as hap_pkg::name.
*/
package hap_pkg;
  localparam int unsigned ADDR_W     = 32'h0000_000D;
  localparam int unsigned DATA_W     = 32'h0000_0008;
  localparam int unsigned SPI_ADDR_W = 32'h0000_000E;
  // Strap and serial pin positions on the shared data bus
  localparam int unsigned PIN_CPOL   = 32'h0000_0007;
  localparam int unsigned PIN_CPHA   = 32'h0000_0006;
  localparam int unsigned PIN_SWAP   = 32'h0000_0005;
  localparam int unsigned PIN_SCLK   = 32'h0000_0002;
  localparam int unsigned PIN_MOSI   = 32'h0000_0001;
  localparam int unsigned PIN_MISO   = 32'h0000_0000;
  // Serial control word: rw flag, burst flag, then 14 address bits
  localparam logic [3:0]  CNT_RW     = 4'h0;
  localparam logic [3:0]  CNT_BURST  = 4'h1;
  localparam logic [3:0]  CTRL_LAST  = 4'hF;
  localparam logic [3:0]  DATA_LAST  = 4'h7;
  localparam logic [7:0]  OE_NONE    = 8'h00;
  localparam logic [7:0]  OE_ALL     = 8'hFF;
  localparam logic [7:0]  OE_MISO    = 8'h01;

  typedef enum logic [1:0] {
    hap_st_idle = 2'b00,
    hap_st_ctrl = 2'b01,
    hap_st_data = 2'b10,
    hap_st_done = 2'b11
  } hap_spi_st_t;
endpackage : hap_pkg

/* rtl/hap_mem_if.sv */
/*
  Interface between the port logic and its register store.
  Assumes a single clock shared by both ends; read data arrive one cycle late.
*/
`timescale 1ns/10ps
interface hap_mem_if #(
  parameter int AW = 13,
  parameter int DW = 8
);
  logic          wr_en;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport ctrl (output wr_en, output addr, output wdata, input rdata);
  modport mem  (input wr_en, input addr, input wdata, output rdata);
endinterface : hap_mem_if

/* rtl/hap_regmem.sv */
/*
  Byte-wide register store addressed by the host port.
  Assumes one access per cycle; read data come from a register one cycle later.
*/
`timescale 1ns/10ps
module hap_regmem #(
  parameter int AW = 13,
  parameter int DW = 8
) (
  input wire logic core_clk,
  hap_mem_if.mem   bus
);
  logic [DW-1:0] store [2**AW];
  logic [DW-1:0] rdata_ff;

  always_ff @(posedge core_clk) begin
    if (bus.wr_en) begin
      store[bus.addr] <= bus.wdata;
    end
    rdata_ff <= store[bus.addr];
  end

  assign bus.rdata = rdata_ff;
endmodule : hap_regmem

/* rtl/hap_port.sv */
/*
  Host register access port: parallel strobe bus or SPI slave, picked by strap.
  Assumes all pins are asynchronous to core_clk and that SCLK is at least eight
  core clocks per period; the data bus wire is resolved outside from d_oe.
*/
// Functional notes
// - Data lines are not driven while chip select is high.
// - Read and write strobes take effect only while chip select is low.
// - In parallel mode the addressed register is driven out while read strobe and select are low.
// - In serial mode data pin 7 gives the clock polarity, low by default.
// - In serial mode data pin 6 gives the clock phase, low by default.
// - In serial mode data pin 5 gives bit order, low for LSB first, high for MSB first.
// - Bit-order swap never moves the rw and burst flags of the control word.
// - In serial mode pin 2 is SCLK in, pin 1 is MOSI in and pin 0 is MISO out.
// - The select strap picks parallel mode at 0 and serial mode at 1.
// - A parallel write stores the bus on the rising write strobe while selected.
`timescale 1ns/10ps
module hap_port #(
  parameter int AW = hap_pkg::ADDR_W,
  parameter int DW = hap_pkg::DATA_W
) (
  input  wire logic          core_clk,
  input  wire logic          rst_n,
  input  wire logic          chip_select_n,
  input  wire logic          read_strobe_n,
  input  wire logic          write_strobe_n,
  input  wire logic          serial_select,
  input  wire logic [AW-1:0] addr_pin,
  input  wire logic [DW-1:0] d_in,
  output logic      [DW-1:0] d_out,
  output logic      [DW-1:0] d_oe,
  output logic               serial_mode,
  output logic               serial_clock_polarity,
  output logic               serial_clock_phase,
  output logic               serial_msb_first,
  output logic               straps_valid
);
  hap_mem_if #(.AW(AW), .DW(DW)) mem_bus ();

  hap_regmem #(.AW(AW), .DW(DW)) u_mem (
    .core_clk (core_clk),
    .bus      (mem_bus.mem)
  );

  function automatic logic [7:0] hap_shift_in(input logic [7:0] v, input logic b,
                                              input logic msb);
    hap_shift_in = msb ? {v[6:0], b} : {b, v[7:1]};
  endfunction : hap_shift_in

  function automatic logic [7:0] hap_shift_out(input logic [7:0] v, input logic msb);
    hap_shift_out = msb ? {v[6:0], 1'b0} : {1'b0, v[7:1]};
  endfunction : hap_shift_out

  // Two-stage synchronisers; only the second stage is read
  logic [DW-1:0] d_m_ff,  d_s_ff;
  logic [AW-1:0] a_m_ff,  a_s_ff;
  logic [3:0]    c_m_ff,  c_s_ff;
  logic          cs_s, rd_s, wr_s, sel_s;

  always_ff @(posedge core_clk) begin
    d_m_ff <= d_in;
    d_s_ff <= d_m_ff;
    a_m_ff <= addr_pin;
    a_s_ff <= a_m_ff;
    c_m_ff <= {chip_select_n, read_strobe_n, write_strobe_n, serial_select};
    c_s_ff <= c_m_ff;
  end

  assign {cs_s, rd_s, wr_s, sel_s} = c_s_ff;

  // Straps are caught once, on the first edge after reset is released
  logic vld_ff, serial_ff, cpol_ff, cpha_ff, msb_ff;
  logic nxt_vld, nxt_serial, nxt_cpol, nxt_cpha, nxt_msb;

  always_comb begin
    nxt_vld    = 1'b1;
    nxt_serial = serial_ff;
    nxt_cpol   = cpol_ff;
    nxt_cpha   = cpha_ff;
    nxt_msb    = msb_ff;
    if (!vld_ff) begin
      nxt_serial = sel_s;
      nxt_cpol   = d_s_ff[hap_pkg::PIN_CPOL];
      nxt_cpha   = d_s_ff[hap_pkg::PIN_CPHA];
      nxt_msb    = d_s_ff[hap_pkg::PIN_SWAP];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      vld_ff    <= 1'b0;
      serial_ff <= 1'b0;
      cpol_ff   <= 1'b0;
      cpha_ff   <= 1'b0;
      msb_ff    <= 1'b0;
    end else begin
      vld_ff    <= nxt_vld;
      serial_ff <= nxt_serial;
      cpol_ff   <= nxt_cpol;
      cpha_ff   <= nxt_cpha;
      msb_ff    <= nxt_msb;
    end
  end

  // Access engine: parallel strobes and the serial shifter
  hap_pkg::hap_spi_st_t             st_ff, nxt_st;
  logic [3:0]                       cnt_ff, nxt_cnt;
  logic [hap_pkg::SPI_ADDR_W-1:0]   saddr_ff, nxt_saddr;
  logic [7:0]                       rx_ff, nxt_rx, tx_ff, nxt_tx;
  logic rw_ff, nxt_rw, burst_ff, nxt_burst, load_ff, nxt_load;
  logic sclk_ff, wr_prev_ff, par_rd_ff, miso_ff, nxt_miso;
  logic [DW-1:0] nxt_d_out, nxt_oe;
  logic par_rd, par_wr, sclk, mosi, edge_seen, lead, trail, smp, shf;

  always_comb begin
    sclk      = d_s_ff[hap_pkg::PIN_SCLK];
    mosi      = d_s_ff[hap_pkg::PIN_MOSI];
    edge_seen = sclk != sclk_ff;
    lead      = edge_seen && (sclk_ff == cpol_ff);
    trail     = edge_seen && (sclk_ff != cpol_ff);
    smp       = cpha_ff ? trail : lead;
    shf       = cpha_ff ? lead : trail;
    par_rd    = vld_ff && !serial_ff && !cs_s && !rd_s;
    par_wr    = vld_ff && !serial_ff && !cs_s && wr_s && !wr_prev_ff;

    nxt_st    = st_ff;
    nxt_cnt   = cnt_ff;
    nxt_saddr = saddr_ff;
    nxt_rx    = rx_ff;
    nxt_tx    = tx_ff;
    nxt_rw    = rw_ff;
    nxt_burst = burst_ff;
    nxt_miso  = miso_ff;
    nxt_load  = 1'b0;
    mem_bus.wr_en = par_wr;
    mem_bus.addr  = a_s_ff;
    mem_bus.wdata = d_s_ff;

    if (!vld_ff || !serial_ff || cs_s) begin
      nxt_st = hap_pkg::hap_st_idle;
    end else begin
      unique case (st_ff)
        hap_pkg::hap_st_idle: begin
          nxt_st   = hap_pkg::hap_st_ctrl;
          nxt_cnt  = '0;
          nxt_miso = 1'b0;
        end
        hap_pkg::hap_st_ctrl: begin
          if (smp) begin
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff == hap_pkg::CNT_RW) begin
              nxt_rw = mosi;
            end else if (cnt_ff == hap_pkg::CNT_BURST) begin
              nxt_burst = mosi;
            end else if (msb_ff) begin
              nxt_saddr = {saddr_ff[hap_pkg::SPI_ADDR_W-2:0], mosi};
            end else begin
              nxt_saddr = {mosi, saddr_ff[hap_pkg::SPI_ADDR_W-1:1]};
            end
            if (cnt_ff == hap_pkg::CTRL_LAST) begin
              nxt_st        = hap_pkg::hap_st_data;
              nxt_cnt       = '0;
              mem_bus.addr  = nxt_saddr[AW-1:0];
              nxt_load      = rw_ff;
            end
          end
        end
        hap_pkg::hap_st_data: begin
          if (shf && rw_ff) begin
            nxt_miso = msb_ff ? tx_ff[DW-1] : tx_ff[0];
            nxt_tx   = hap_shift_out(tx_ff, msb_ff);
          end
          if (smp) begin
            nxt_rx  = hap_shift_in(rx_ff, mosi, msb_ff);
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff == hap_pkg::DATA_LAST) begin
              nxt_cnt = '0;
              if (!rw_ff) begin
                mem_bus.wr_en = 1'b1;
                mem_bus.addr  = saddr_ff[AW-1:0];
                mem_bus.wdata = nxt_rx;
              end
              if (burst_ff) begin
                nxt_saddr    = saddr_ff + 14'h0001;
                mem_bus.addr = rw_ff ? nxt_saddr[AW-1:0] : mem_bus.addr;
                nxt_load     = rw_ff;
              end else begin
                nxt_st = hap_pkg::hap_st_done;
              end
            end
          end
        end
        hap_pkg::hap_st_done: begin
          nxt_st = hap_pkg::hap_st_done;
        end
      endcase
    end
    // Reload wins; the next shift edge is several core clocks away
    if (load_ff) begin
      nxt_tx = mem_bus.rdata;
    end

    nxt_oe    = hap_pkg::OE_NONE;
    nxt_d_out = mem_bus.rdata;
    if (par_rd_ff && par_rd) begin
      nxt_oe = hap_pkg::OE_ALL;
    end else if (vld_ff && serial_ff && !cs_s) begin
      nxt_oe    = hap_pkg::OE_MISO;
      nxt_d_out = {{(DW-1){1'b0}}, nxt_miso};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_ff      <= hap_pkg::hap_st_idle;
      cnt_ff     <= '0;
      saddr_ff   <= '0;
      rx_ff      <= '0;
      tx_ff      <= '0;
      rw_ff      <= 1'b0;
      burst_ff   <= 1'b0;
      load_ff    <= 1'b0;
      miso_ff    <= 1'b0;
      sclk_ff    <= 1'b0;
      wr_prev_ff <= 1'b1;
      par_rd_ff  <= 1'b0;
      d_out      <= '0;
      d_oe       <= hap_pkg::OE_NONE;
    end else begin
      st_ff      <= nxt_st;
      cnt_ff     <= nxt_cnt;
      saddr_ff   <= nxt_saddr;
      rx_ff      <= nxt_rx;
      tx_ff      <= nxt_tx;
      rw_ff      <= nxt_rw;
      burst_ff   <= nxt_burst;
      load_ff    <= nxt_load;
      miso_ff    <= nxt_miso;
      sclk_ff    <= sclk;
      wr_prev_ff <= wr_s;
      par_rd_ff  <= par_rd;
      d_out      <= nxt_d_out;
      d_oe       <= nxt_oe;
    end
  end

  assign serial_mode           = serial_ff;
  assign serial_clock_polarity = cpol_ff;
  assign serial_clock_phase    = cpha_ff;
  assign serial_msb_first      = msb_ff;
  assign straps_valid          = vld_ff;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_oe_cs_high: assert property (cs_s |=> d_oe == hap_pkg::OE_NONE)
    else $error("data bus driven while chip select high");
  a_no_access_unsel: assert property (cs_s |-> !mem_bus.wr_en)
    else $error("register write while chip select high");
  a_par_read_out: assert property (par_rd ##1 par_rd |=> d_oe == hap_pkg::OE_ALL
                                   && d_out == $past(mem_bus.rdata))
    else $error("parallel read not driven with register data");
  a_cpol_strap: assert property ($rose(vld_ff) |->
                                 cpol_ff == $past(d_s_ff[hap_pkg::PIN_CPOL]))
    else $error("clock polarity strap not taken");
  a_cpha_strap: assert property ($rose(vld_ff) |->
                                 cpha_ff == $past(d_s_ff[hap_pkg::PIN_CPHA]))
    else $error("clock phase strap not taken");
  a_order_strap: assert property ($rose(vld_ff) |->
                                  msb_ff == $past(d_s_ff[hap_pkg::PIN_SWAP]))
    else $error("bit order strap not taken");
  a_rw_flag_first: assert property (st_ff == hap_pkg::hap_st_ctrl && smp
                                    && cnt_ff == hap_pkg::CNT_RW
                                    |=> rw_ff == $past(mosi))
    else $error("rw flag not taken from first control bit");
  a_miso_only: assert property (vld_ff && serial_ff && !cs_s ##1 !cs_s
                                |-> d_oe == hap_pkg::OE_MISO)
    else $error("serial mode drives more than the miso pin");
  a_mode_strap: assert property ($rose(vld_ff) |-> serial_ff == $past(sel_s))
    else $error("mode strap not taken");
  a_par_write: assert property (vld_ff && !serial_ff && !cs_s && $rose(wr_s)
                                |-> mem_bus.wr_en && mem_bus.wdata == d_s_ff)
    else $error("parallel write not stored on rising strobe");

  c_par_read:   cover property (par_rd [*3] ##1 !par_rd);
  c_par_write:  cover property (par_wr);
  c_spi_read:   cover property (st_ff == hap_pkg::hap_st_data && rw_ff && load_ff);
  c_spi_burst:  cover property (st_ff == hap_pkg::hap_st_data && burst_ff && nxt_load);
endmodule : hap_port

/* verif/hap_host_model.sv */
/*
  Host model: drives the parallel strobe bus or a serial frame on the shared pins.
  Assumes the bench resolves the data wire from h_oe and the device's d_oe.
*/
`timescale 1ns/10ps
module hap_host_model (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        spi_m,
  input  wire logic [2:0]  straps,
  input  wire logic [7:0]  d_in,
  input  wire logic [7:0]  d_oe,
  output logic             chip_select_n,
  output logic             read_strobe_n,
  output logic             write_strobe_n,
  output logic [12:0]      addr_pin,
  output logic [7:0]       h_d,
  output logic [7:0]       h_oe,
  output logic             hung
);
  logic [7:0] pd;
  logic       pe;
  logic       sclk;
  logic       mosi;

  // Straps held through reset and the whole serial session; SCLK idles at its polarity
  assign h_oe = spi_m ? 8'hFE : (!rst_n ? 8'hE0 : {8{pe}});
  assign h_d  = spi_m ? {straps, 2'h0, sclk ^ straps[2], mosi, 1'h0} :
                (!rst_n ? {straps, 5'h00} : pd);

  initial begin
    chip_select_n = 1'h1;
    read_strobe_n = 1'h1;
    write_strobe_n = 1'h1;
    addr_pin = 13'h0000;
    pd = 8'h00;
    pe = 1'h0;
    sclk = 1'h0;
    mosi = 1'h0;
    hung = 1'h0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  // Select held around the whole strobe, data kept 3 clocks past its rise
  task automatic par_wr(input logic [12:0] a, input logic [7:0] d, input logic sel);
    tick(1);
    chip_select_n = ~sel;
    addr_pin = a;
    // Wrong data until the strobe falls, so a capture before the strobe falls shows up
    pd = ~d;
    pe = 1'h1;
    tick(1);
    write_strobe_n = 1'h0;
    pd = d;
    tick(3);
    write_strobe_n = 1'h1;
    tick(3);
    chip_select_n = 1'h1;
    pe = 1'h0;
    tick(3);
  endtask : par_wr

  task automatic par_rd(input logic [12:0] a, input logic sel, output logic [15:0] r);
    tick(1);
    chip_select_n = ~sel;
    read_strobe_n = 1'h0;
    addr_pin = a;
    for (int i = 0; i < 8 && d_oe !== 8'hFF; i++) tick(1);
    if (sel && d_oe !== 8'hFF) hung = 1'h1;
    r = {d_oe, d_in};
    chip_select_n = 1'h1;
    read_strobe_n = 1'h1;
    tick(4);
  endtask : par_rd

  // A burst session carries wd, then ~wd for the next address; r keeps the last byte
  task automatic spi(input logic rw, input logic bst, input logic [12:0] a,
                     input logic [7:0] wd, output logic [15:0] r);
    logic [13:0] aw;
    int k;
    int j;
    aw = {1'h0, a};
    tick(1);
    chip_select_n = 1'h0;
    tick(4);
    r[15:8] = d_oe;
    for (int i = 0; i < (bst ? 32 : 24); i++) begin
      j = (i < 16) ? i : (i - 16) % 8;
      k = (i < 16) ? (straps[0] ? 15 - i : i - 2) : (straps[0] ? 7 - j : j);
      // Flags go first and never move; only address and data follow the order strap
      if (straps[1]) sclk = 1'h1;
      mosi = (i == 0) ? rw : (i == 1) ? bst : (i < 16) ? aw[k] : (i < 24) ? wd[k] : ~wd[k];
      tick(4);
      sclk = ~sclk;
      if (i > 15) r[k] = d_in[0];
      tick(4);
      if (!straps[1]) sclk = 1'h0;
    end
    tick(4);
    chip_select_n = 1'h1;
    tick(4);
  endtask : spi
endmodule : hap_host_model

/* verif/host_register_access_port_tb_top.sv */
/*
  Self-checking bench for the host register access port, both strap modes.
  Assumes the host model in verif/ and the port's rtl; the bench resolves the data wire.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module host_register_access_port_tb_top;
  logic        core_clk;
  logic        rst_n = 1'h0;
  logic        spi_m = 1'h0;
  logic [2:0]  straps = 3'h0;
  logic        chip_select_n;
  logic        read_strobe_n;
  logic        write_strobe_n;
  logic [12:0] addr_pin;
  logic [7:0]  h_d;
  logic [7:0]  h_oe;
  logic        hung;
  logic [7:0]  d_in;
  logic [7:0]  d_out;
  logic [7:0]  d_oe;
  logic        serial_mode;
  logic        serial_clock_polarity;
  logic        serial_clock_phase;
  logic        serial_msb_first;
  logic        straps_valid;
  logic [7:0]  flt = 8'h5A;
  logic [31:0] seed = 32'h0000_c612;
  int          n_mismatch = 0;
  int          checked = 0;

  // Released lines toggle so a stale value can never pass for an answer
  assign d_in = (d_oe & d_out) | (~d_oe & h_oe & h_d) | (~d_oe & ~h_oe & flt);

  hap_port dut (.core_clk, .rst_n, .chip_select_n, .read_strobe_n, .write_strobe_n,
    .serial_select(spi_m), .addr_pin, .d_in, .d_out, .d_oe, .serial_mode,
    .serial_clock_polarity, .serial_clock_phase, .serial_msb_first, .straps_valid);
  hap_host_model host (.core_clk, .rst_n, .spi_m, .straps, .d_in, .d_oe, .chip_select_n,
    .read_strobe_n, .write_strobe_n, .addr_pin, .h_d, .h_oe, .hung);

  initial begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) #1 flt = ~flt;
  always @(posedge hung) begin
    n_mismatch++;
    give_verdict();
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Expected capture of a read: enables seen on the bus, then the byte
  function automatic logic [15:0] rd_exp(input logic spi, input logic [7:0] d);
    return {spi ? 8'h01 : 8'hFF, d};
  endfunction : rd_exp

  task automatic give_verdict;
    if (n_mismatch == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic do_reset(input logic m, input logic [2:0] s);
    spi_m = m;
    straps = s;
    rst_n = 1'h0;
    host.tick(4);
    `CHK(d_oe, 8'h00)
    rst_n = 1'h1;
    host.tick(1);
    `CHK({straps_valid, serial_mode}, {1'h1, m})
    if (m) `CHK({serial_clock_polarity, serial_clock_phase, serial_msb_first}, s)
  endtask : do_reset

  initial begin
    logic [12:0] a;
    logic [7:0]  d;
    logic [15:0] r;
    logic [12:0] q[$];
    logic [7:0]  mem[logic [12:0]];
    do_reset(1'h0, 3'h0);
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      a = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1FFF : seed[12:0];
      d = seed[20:13];
      host.par_wr(a, d, 1'h1);
      mem[a] = d;
      q.push_back(a);
    end
    foreach (q[j]) begin
      host.par_rd(q[j], 1'h1, r);
      `CHK(r, rd_exp(1'h0, mem[q[j]]))
      `CHK(d_oe, 8'h00)
    end
    // Strobes without select must touch neither the store nor the bus
    host.par_wr(q[0], ~mem[q[0]], 1'h0);
    host.par_rd(q[0], 1'h0, r);
    `CHK(r[15:8], 8'h00)
    host.par_rd(q[0], 1'h1, r);
    `CHK(r, rd_exp(1'h0, mem[q[0]]))
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      a = seed[12:0];
      d = seed[20:13];
      do_reset(1'h1, k[2:0]);
      // Bursts cover both bit orders and both clock phases
      host.spi(1'h0, k[2] ^ k[0], a, d, r);
      host.spi(1'h1, 1'h0, a, 8'h00, r);
      `CHK(r, rd_exp(1'h1, d))
      if (k[2] ^ k[0]) begin
        host.spi(1'h1, 1'h1, a, 8'h00, r);
        `CHK(r, rd_exp(1'h1, ~d))
      end
    end
    give_verdict();
  end
endmodule : host_register_access_port_tb_top
